// [hdl/pcs_capability_structure.sv]
// Purpose: express capability item and device capabilities registers
// Assumes: configuration reads/writes and messages synchronous to mclk
// Notes: all fields read-only to software; writes are ignored
// Function
// (RULE1) capability identifier byte always reads 10h
// (RULE2) next-item byte reads 00h, ending the list
// (RULE3) interrupt message number bits 13:9 are zero, writes ignored
// (RULE4) slot implemented bit 8 always reads zero
// (RULE5) bits 7:4 read 7h, a express-to-legacy bridge
// (RULE6) version bits 3:0 read 1h; bits 15:14 read zero
// (RULE7) power message payload bits 9:8 land in bits 27:26
// (RULE8) power message payload bits 7:0 land in bits 25:18
// (RULE9) scale codes 0..3 multiply value by 1.0, 0.1, 0.01, 0.001
// (RULE10) bits 11:9 mirror control bits 15:13, reset 110b
// (RULE11) bits 8:6 mirror control bits 18:16, reset 110b
// (RULE12) latency fields never below the phy exit latency
// (RULE13) indicator and button bits 14:12 read zero
// (RULE14) phantom function bits 4:3 read 00b
// (RULE15) bits 2:0 read 010b, 512-byte payload
// (RULE16) extended tag bit 5 reads zero
// (RULE17) reserved bits 31:28 and 17:15 read zero
// (RULE18) device capabilities read 0000_0D82h after reset
// (RULE19) scale and value update together in one cycle
`timescale 1ns/100ps
`include "pcs_defines.svh"

module pcs_capability_structure
   import pcs_pkg::*;
#(
   parameter int LAT_W = 3
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire pcs_cfg_req_t cfgReq,
   input wire pcs_slot_msg_t slotMsg,
   input wire logic [31:0] genCtrl,
   input wire logic [LAT_W-1:0] phyDeepExit,
   input wire logic [LAT_W-1:0] phyLightExit,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   output logic cfgHit,
   output logic [17:0] powerLimitMw
);

   ////////////////////////////////////////////////////////////////////////
   // reset release

   logic [1:0] rstPipe_q;
   logic rstSync_n;

   // async assert, two-flop release so all state leaves reset together
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe_q <= 2'h0;
      end else begin
         rstPipe_q <= {rstPipe_q[0], 1'b1};
      end
   end

   assign rstSync_n = rstPipe_q[1];

   ////////////////////////////////////////////////////////////////////////
   // helper functions

   // device capabilities word from its live fields
   function automatic logic [31:0] devCapWord(input logic [1:0] sc,
                                              input logic [7:0] val,
                                              input logic [2:0] deep,
                                              input logic [2:0] light);
      logic [31:0] w;
      w = 32'h0; // [RULE13] [RULE14] [RULE16] [RULE17]
      w[`PCS_SCALE_LSB +: 2] = sc;
      w[`PCS_VALUE_LSB +: 8] = val;
      w[`PCS_DEEP_LSB +: 3] = deep;
      w[`PCS_LIGHT_LSB +: 3] = light;
      w[2:0] = `PCS_MAX_PAYLOAD_VAL; // [RULE15]
      devCapWord = w;
   endfunction : devCapWord

   // milliwatt multiplier per scale code
   function automatic logic [9:0] scaleMult(input logic [1:0] sc);
      logic [9:0] m;
      m = 10'h001;
      unique case (sc)
         2'h0: m = 10'h3E8;
         2'h1: m = 10'h064;
         2'h2: m = 10'h00A;
         2'h3: m = 10'h001;
      endcase
      scaleMult = m;
   endfunction : scaleMult

   ////////////////////////////////////////////////////////////////////////
   // captured slot power limit

   pcs_power_pair_t power_q;
   pcs_power_pair_t power_d;
   logic [17:0] powerMw_q;
   logic [17:0] powerMw_d;

   // scale and value taken from one message
   assign power_d.scale = slotMsg.payload[`PCS_MSG_SCALE_LSB +: 2]; // [RULE7]
   assign power_d.value = slotMsg.payload[7:0]; // [RULE8]

   // pair written as one word: no torn read possible
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         power_q <= '0; // [RULE18]
      end else if (slotMsg.valid) begin
         power_q <= power_d; // [RULE19]
      end
   end

   // limit in milliwatts; value 255 at 1.0x fits 18 bits
   assign powerMw_d = 18'(power_q.value * scaleMult(power_q.scale)); // [RULE9]

   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         powerMw_q <= 18'h0;
      end else begin
         powerMw_q <= powerMw_d;
      end
   end

   assign powerLimitMw = powerMw_q;

   ////////////////////////////////////////////////////////////////////////
   // acceptable-latency mirrors

   logic [LAT_W-1:0] deepTol;
   logic [LAT_W-1:0] lightTol;
   logic [LAT_W-1:0] deepSetting;
   logic [LAT_W-1:0] lightSetting;

   assign deepSetting = genCtrl[`PCS_GC_DEEP_LSB +: LAT_W]; // [RULE10]
   assign lightSetting = genCtrl[`PCS_GC_LIGHT_LSB +: LAT_W]; // [RULE11]

   // clamp inside tracker keeps the field at or above the phy floor
   pcs_latency_tracker #(
      .W(LAT_W),
      .RST_VAL(`PCS_LAT_RST)
   ) u_deep_idle_exit_tolerance (
      .clk(mclk),
      .rstSync_n(rstSync_n),
      .setting(deepSetting),
      .floorCode(phyDeepExit), // [RULE12]
      .tolerance(deepTol)
   );

   pcs_latency_tracker #(
      .W(LAT_W),
      .RST_VAL(`PCS_LAT_RST)
   ) u_light_idle_exit_tolerance (
      .clk(mclk),
      .rstSync_n(rstSync_n),
      .setting(lightSetting),
      .floorCode(phyLightExit), // [RULE12]
      .tolerance(lightTol)
   );

   ////////////////////////////////////////////////////////////////////////
   // register images and read decode

   logic [7:0] capIdByte;
   logic [7:0] nextItemByte;
   logic [15:0] expCapWord;
   logic [31:0] devCapImage;
   logic [31:0] itemWord;
   logic hitItem;
   logic hitDev;
   logic [31:0] rdData_d;

   assign capIdByte = `PCS_CAP_ID_VAL; // [RULE1]
   assign nextItemByte = `PCS_NEXT_VAL; // [RULE2]

   // constant word; no write path exists, so hardwired bits stay put
   assign expCapWord = {2'h0, // [RULE6]
                        5'h00, // [RULE3]
                        1'b0, // [RULE4]
                        `PCS_PORT_KIND, // [RULE5]
                        `PCS_CAP_VERSION}; // [RULE6]

   // zero bits come from devCapWord starting from all zeros
   assign devCapImage = devCapWord(power_q.scale, power_q.value,
                                   deepTol, lightTol);

   assign itemWord = {expCapWord, nextItemByte, capIdByte};

   // dword decode; byte lanes are the caller's business
   assign hitItem = (cfgReq.addr[7:2] == 6'(`PCS_OFS_CAP_ID >> 2));
   assign hitDev = (cfgReq.addr[7:2] == 6'(`PCS_OFS_DEV_CAP >> 2));
   assign rdData_d = hitItem ? itemWord :
                     hitDev ? devCapImage : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // read answer, one cycle after the request

   logic [31:0] rdData_q;
   logic rdValid_q;
   logic hit_q;

   // writes are accepted silently and change nothing
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rdData_q <= 32'h0;
         rdValid_q <= 1'b0;
         hit_q <= 1'b0;
      end else begin
         rdData_q <= cfgReq.rd ? rdData_d : 32'h0;
         rdValid_q <= cfgReq.rd;
         hit_q <= cfgReq.rd & (hitItem | hitDev);
      end
   end

   assign cfgRdData = rdData_q;
   assign cfgRdValid = rdValid_q;
   assign cfgHit = hit_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic rdItem_q;
   logic rdDev_q;
   logic firstCycle_q;

   // flags which word a read in the previous cycle aimed at; cleared when no read
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rdItem_q <= 1'b0;
         rdDev_q <= 1'b0;
         firstCycle_q <= 1'b1;
      end else begin
         rdItem_q <= cfgReq.rd & hitItem;
         rdDev_q <= cfgReq.rd & hitDev;
         firstCycle_q <= 1'b0;
      end
   end

   property p_cap_id;
      @(posedge mclk) disable iff (!rstSync_n)
      rdValid_q && rdItem_q |-> rdData_q[7:0] == 8'h10;
   endproperty
   a_cap_id: assert property (p_cap_id) // [RULE1]
      else $error("express_capability_identifier wrong");

   property p_next_item;
      @(posedge mclk) disable iff (!rstSync_n)
      cfgReq.rd && hitItem |=> rdData_q[15:8] == 8'h00;
   endproperty
   a_next_item: assert property (p_next_item) // [RULE2]
      else $error("next item byte not zero");

   property p_exp_cap;
      @(posedge mclk) disable iff (!rstSync_n)
      rdValid_q && rdItem_q |-> rdData_q[31:16] == 16'h0071;
   endproperty
   a_exp_cap: assert property (p_exp_cap) // [RULE3] [RULE4] [RULE5] [RULE6]
      else $error("capabilities word wrong");

   property p_capture;
      @(posedge mclk) disable iff (!rstSync_n)
      slotMsg.valid |=> power_q.scale == $past(slotMsg.payload[9:8])
         && power_q.value == $past(slotMsg.payload[7:0]);
   endproperty
   a_capture: assert property (p_capture) // [RULE7] [RULE8] [RULE19]
      else $error("power pair not captured");

   property p_hold;
      @(posedge mclk) disable iff (!rstSync_n)
      !slotMsg.valid |=> $stable(power_q);
   endproperty
   a_hold: assert property (p_hold) // [RULE19]
      else $error("power pair changed without message");

   property p_power_mw;
      @(posedge mclk) disable iff (!rstSync_n)
      ##1 (power_q.scale == 2'h1) |=>
         powerMw_q == 18'($past(power_q.value)) * 18'h00064;
   endproperty
   a_power_mw: assert property (p_power_mw) // [RULE9]
      else $error("power limit at 0.1x wrong");

   property p_power_whole;
      @(posedge mclk) disable iff (!rstSync_n)
      ##1 (power_q.scale == 2'h0) |=>
         powerMw_q == 18'($past(power_q.value)) * 18'h003E8;
   endproperty
   a_power_whole: assert property (p_power_whole) // [RULE9]
      else $error("power limit at 1.0x wrong");

   // gated on the sampled reset copy: the first edge still holds 110b
   property p_deep_floor;
      @(posedge mclk) disable iff (!rstSync_n)
      rstSync_n |=> deepTol >= $past(phyDeepExit)
         && deepTol >= $past(deepSetting);
   endproperty
   a_deep_floor: assert property (p_deep_floor) // [RULE10] [RULE12]
      else $error("deep idle tolerance below floor or setting");

   property p_deep_mirror;
      @(posedge mclk) disable iff (!rstSync_n)
      rstSync_n && deepSetting >= phyDeepExit |=>
         deepTol == $past(deepSetting);
   endproperty
   a_deep_mirror: assert property (p_deep_mirror) // [RULE10]
      else $error("deep idle tolerance not mirrored");

   property p_deep_clamp;
      @(posedge mclk) disable iff (!rstSync_n)
      rstSync_n && deepSetting < phyDeepExit |=>
         deepTol == $past(phyDeepExit);
   endproperty
   a_deep_clamp: assert property (p_deep_clamp) // [RULE12]
      else $error("deep idle tolerance not held at floor");

   property p_light_mirror;
      @(posedge mclk) disable iff (!rstSync_n)
      rstSync_n && lightSetting >= phyLightExit |=>
         lightTol == $past(lightSetting);
   endproperty
   a_light_mirror: assert property (p_light_mirror) // [RULE11] [RULE12]
      else $error("light idle tolerance not mirrored");

   property p_light_clamp;
      @(posedge mclk) disable iff (!rstSync_n)
      rstSync_n && lightSetting < phyLightExit |=>
         lightTol == $past(phyLightExit);
   endproperty
   a_light_clamp: assert property (p_light_clamp) // [RULE11] [RULE12]
      else $error("light idle tolerance not held at floor");

   property p_dev_fixed;
      @(posedge mclk) disable iff (!rstSync_n)
      rdValid_q && rdDev_q |-> rdData_q[31:28] == 4'h0
         && rdData_q[17:12] == 6'h00;
   endproperty
   a_dev_fixed: assert property (p_dev_fixed) // [RULE13] [RULE17]
      else $error("fixed device capability bits wrong");

   property p_dev_low;
      @(posedge mclk) disable iff (!rstSync_n)
      rdValid_q && rdDev_q |-> rdData_q[5:0] == 6'h02;
   endproperty
   a_dev_low: assert property (p_dev_low) // [RULE14] [RULE15] [RULE16]
      else $error("payload, phantom or tag bits wrong");

   property p_reset_pair;
      @(posedge mclk) disable iff (!rstSync_n)
      firstCycle_q |-> power_q.scale == 2'h0 && power_q.value == 8'h00
         && powerMw_q == 18'h00000;
   endproperty
   a_reset_pair: assert property (p_reset_pair) // [RULE18]
      else $error("captured power not zero after reset");

   property p_reset_word;
      @(posedge mclk) disable iff (!rstSync_n)
      firstCycle_q |-> devCapImage == 32'h0000_0D82;
   endproperty
   a_reset_word: assert property (p_reset_word) // [RULE18]
      else $error("device capabilities reset value wrong");

endmodule : pcs_capability_structure

// [hdl/pcs_defines.svh]
// Purpose: offsets, field positions and fixed values of the capability
// Assumes: byte offsets in configuration space, dword-wide reads
// Notes: definitions only
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// offsets
`define PCS_OFS_CAP_ID 8'h90
`define PCS_OFS_NEXT 8'h91
`define PCS_OFS_EXP_CAP 8'h92
`define PCS_OFS_DEV_CAP 8'h94

// fixed identity bytes of the list item
`define PCS_CAP_ID_VAL 8'h10
`define PCS_NEXT_VAL 8'h00

// capabilities word fields
`define PCS_EXP_CAP_RST 16'h0071
`define PCS_PORT_KIND 4'h7
`define PCS_CAP_VERSION 4'h1

// device capabilities word
`define PCS_DEV_CAP_RST 32'h0000_0D82
`define PCS_MAX_PAYLOAD_VAL 3'h2
`define PCS_LAT_RST 3'h6
`define PCS_SCALE_LSB 26
`define PCS_VALUE_LSB 18
`define PCS_DEEP_LSB 9
`define PCS_LIGHT_LSB 6

// sources of captured and mirrored fields
`define PCS_MSG_SCALE_LSB 8
`define PCS_GC_DEEP_LSB 13
`define PCS_GC_LIGHT_LSB 16

`endif

// [hdl/pcs_pkg.sv]
// Purpose: types shared by the capability structure files
// Assumes: constants live in pcs_defines.svh
// Notes: carriers for the configuration port and the power message
package pcs_pkg;

   // one configuration access, byte address
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } pcs_cfg_req_t;

   // slot power message as delivered by the link layer
   typedef struct packed {
      logic valid;
      logic [9:0] payload;
   } pcs_slot_msg_t;

   // captured pair, updated as one unit
   typedef struct packed {
      logic [1:0] scale;
      logic [7:0] value;
   } pcs_power_pair_t;

endpackage : pcs_pkg

// [hdl/pcs_latency_tracker.sv]
// Purpose: mirrors one acceptable-latency setting with a floor clamp
// Assumes: setting and floor synchronous to clk
// Notes: instantiated once per low-power state
`timescale 1ns/100ps
`include "pcs_defines.svh"

module pcs_latency_tracker #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = `PCS_LAT_RST
) (
   input wire logic clk,
   input wire logic rstSync_n,
   input wire logic [W-1:0] setting,
   input wire logic [W-1:0] floorCode,
   output logic [W-1:0] tolerance
);

   logic [W-1:0] tolerance_q;
   logic [W-1:0] tolerance_d;

   // never below the phy exit latency
   function automatic logic [W-1:0] clampUp(input logic [W-1:0] s,
                                            input logic [W-1:0] f);
      clampUp = (s < f) ? f : s;
   endfunction : clampUp

   assign tolerance_d = clampUp(setting, floorCode);
   assign tolerance = tolerance_q;

   // follows the setting one cycle later
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         tolerance_q <= RST_VAL;
      end else begin
         tolerance_q <= tolerance_d;
      end
   end

endmodule : pcs_latency_tracker

// [sim/pcs_root_model.sv]
// Purpose: root complex stand-in issuing config accesses and power messages
// Assumes: callers enter each task 1 ns after a rising mclk edge
// Notes: released fields carry inverted data so stale values never match
`timescale 1ns/100ps

module pcs_root_model
   import pcs_pkg::*;
(
   input wire logic mclk,
   input wire logic [31:0] cfgRdData,
   input wire logic cfgRdValid,
   input wire logic cfgHit,
   output pcs_cfg_req_t cfgReq,
   output pcs_slot_msg_t slotMsg
);
   localparam time SKEW = 1ns;

   // idle at time zero
   initial begin
      cfgReq = '0;
      slotMsg = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one read: rd is a single-cycle pulse, answer waited for a few edges
   task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
                           output logic h, output bit ok);
      int n;
      ok = 1'b0;
      cfgReq.rd = 1'b1;
      cfgReq.addr = a;
      @(posedge mclk);
      #SKEW;
      cfgReq.rd = 1'b0;
      cfgReq.addr = ~a;
      for (n = 0; n < 4 && !ok; n++) begin
         if (cfgRdValid === 1'b1) begin
            d = cfgRdData;
            h = cfgHit;
            ok = 1'b1;
         end
         @(posedge mclk);
         #SKEW;
      end
   endtask : cfg_read

   // writes get no answer; one idle edge keeps drivers single-assigned
   task automatic cfg_write(input logic [7:0] a, input logic [31:0] w);
      cfgReq.wr = 1'b1;
      cfgReq.addr = a;
      cfgReq.wdata = w;
      @(posedge mclk);
      #SKEW;
      cfgReq.wr = 1'b0;
      cfgReq.addr = ~a;
      cfgReq.wdata = ~w;
      @(posedge mclk);
      #SKEW;
   endtask : cfg_write

   // more=1 keeps valid up so the next message follows back to back
   task automatic send_msg(input logic [9:0] p, input bit more);
      if (!slotMsg.valid) slotMsg.valid = 1'b1;
      slotMsg.payload = p;
      @(posedge mclk);
      #SKEW;
      if (!more) begin
         slotMsg.valid = 1'b0;
         slotMsg.payload = ~p;
         @(posedge mclk);
         #SKEW;
      end
   endtask : send_msg
endmodule : pcs_root_model

// [sim/pcs_capability_structure_tb_top.sv]
// Purpose: self-checking bench for the capability structure
// Assumes: reads answer within four edges
// Notes: expectations built from field layout, not from the design
`timescale 1ns/100ps

module pcs_capability_structure_tb_top;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] genCtrl = 32'h0006_C000;
   logic [2:0] phyDeepExit = 3'h0;
   logic [2:0] phyLightExit = 3'h0;
   pcs_pkg::pcs_cfg_req_t cfgReq;
   pcs_pkg::pcs_slot_msg_t slotMsg;
   logic [31:0] cfgRdData;
   logic cfgRdValid;
   logic cfgHit;
   logic [17:0] powerLimitMw;
   int badCount = 0;
   int testsRun = 0;
   int mult[4] = '{1000, 100, 10, 1};
   logic [7:0] vTab[4] = '{8'hFF, 8'h01, 8'h80, 8'h7E};

   always #50 mclk = ~mclk;

   pcs_capability_structure uut (.mclk(mclk), .rst_n(rst_n),
      .cfgReq(cfgReq), .slotMsg(slotMsg), .genCtrl(genCtrl),
      .phyDeepExit(phyDeepExit), .phyLightExit(phyLightExit),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .cfgHit(cfgHit),
      .powerLimitMw(powerLimitMw));

   pcs_root_model rc (.mclk(mclk), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .cfgHit(cfgHit), .cfgReq(cfgReq),
      .slotMsg(slotMsg));

   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", testsRun, badCount);
      if (badCount == 0 && testsRun > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   task automatic chk_data(input string w, input logic [31:0] e, g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask : chk_data

   task automatic chk_bit(input string w, input logic e, g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("Error %s expected %b seen %b", w, e, g);
      end
   endtask : chk_bit

   task automatic chk_power(input string w, input logic [17:0] e, g);
      testsRun++;
      if (g !== e) begin
         badCount++;
         $display("Error %s expected %0d seen %0d", w, e, g);
      end
   endtask : chk_power

   // a missing answer ends the run: later reads would misalign
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic eh, input string w);
      logic [31:0] d;
      logic h;
      bit ok;
      rc.cfg_read(a, d, h, ok);
      if (!ok) begin
         badCount++;
         $display("Error %s expected answer seen none", w);
         summarize();
      end
      chk_data(w, e, d);
      chk_bit(w, eh, h);
      // the answer stands one cycle only
      chk_bit({w, " valid"}, 1'b0, cfgRdValid);
   endtask : rd_chk

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
   endtask : do_reset

   function automatic logic [31:0] devw(input logic [1:0] s,
      input logic [7:0] v, input logic [2:0] dp, lt);
      return {4'h0, s, v, 6'h00, dp, lt, 3'h0, 3'h2};
   endfunction : devw

   function automatic logic [31:0] gc(input logic [2:0] dp, lt);
      return {13'h0000, lt, dp, 13'h0000};
   endfunction : gc

   ////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      rd_chk(8'h90, 32'h0071_0010, 1'b1, "cap item");
      rd_chk(8'h94, 32'h0000_0D82, 1'b1, "dev cap");
      rd_chk(8'h95, 32'h0000_0D82, 1'b1, "dev lane");
      rd_chk(8'h93, 32'h0071_0010, 1'b1, "cap lane");
      rd_chk(8'h98, 32'h0000_0000, 1'b0, "unmapped");
      chk_power("power reset", 18'h00000, powerLimitMw);
      $display("test reset values done");
      rc.cfg_write(8'h90, 32'hFFFF_FFFF);
      rc.cfg_write(8'h94, 32'hFFFF_FFFF);
      rd_chk(8'h90, 32'h0071_0010, 1'b1, "cap wr");
      rd_chk(8'h94, 32'h0000_0D82, 1'b1, "dev wr");
      $display("test write ignored done");
      // every scale code, values FFh, 01h, 80h and 7Eh in turn
      for (int s = 0; s < 4; s++) begin
         rc.send_msg({2'(s), vTab[s]}, 1'b0);
         rd_chk(8'h94, devw(2'(s), vTab[s], 3'h6, 3'h6), 1'b1,
            "pair");
         chk_power("power", 18'(int'(vTab[s]) * mult[s]),
            powerLimitMw);
      end
      rc.send_msg(10'h123, 1'b1);
      rc.send_msg(10'h245, 1'b0);
      rd_chk(8'h94, devw(2'h2, 8'h45, 3'h6, 3'h6), 1'b1,
         "last msg");
      chk_power("power last", 18'h002B2, powerLimitMw);
      $display("test power messages done");
      // settings swept across both floors
      phyDeepExit = 3'h3;
      phyLightExit = 3'h5;
      for (int i = 0; i < 8; i++) begin
         genCtrl = gc(3'(i), 3'(7 - i));
         @(posedge mclk);
         #1;
         rd_chk(8'h94, devw(2'h2, 8'h45, (i < 3) ? 3'h3 : 3'(i),
            (7 - i < 5) ? 3'h5 : 3'(7 - i)), 1'b1,
            "latency");
      end
      $display("test latency mirror done");
      genCtrl = gc(3'h6, 3'h6);
      phyDeepExit = 3'h0;
      phyLightExit = 3'h0;
      do_reset();
      rd_chk(8'h94, 32'h0000_0D82, 1'b1, "dev rerst");
      chk_power("power rerst", 18'h00000, powerLimitMw);
      $display("test second reset done");
      summarize();
   end
endmodule : pcs_capability_structure_tb_top
